/* rtl/nvmrap_config_space.sv */
// User ID, identification and configuration word space
`timescale 1ns/100ps
module nvmrap_config_space
#(
    parameter int DATA_WIDTH = 14,
    // Arbitrary identity values, not tied to any real part
    parameter logic [15:0] DEVICE_ID = 16'h1234,
    parameter logic [15:0] REVISION_ID = 16'h0001,
    parameter logic [15:0] CONFIG_WORD = 16'h3fff
)
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Access
    input wire logic [3:0] i_addr,
    input wire logic i_wr_en,
    input wire logic [DATA_WIDTH-1:0] i_wr_data,
    output logic [DATA_WIDTH-1:0] o_rd_data,
    output logic o_writable
);
    logic [DATA_WIDTH-1:0] user_id [0:3];
    logic [DATA_WIDTH-1:0] next_rd_data;
    wire logic is_user = (i_addr[3:2] == 2'h0);

    // Only the user ID words take writes; the rest is read-only
    assign o_writable = is_user; // R5

    always_comb
    begin
        next_rd_data = '0;
        case (i_addr)
            4'h6: next_rd_data = DEVICE_ID[DATA_WIDTH-1:0];
            4'h5: next_rd_data = REVISION_ID[DATA_WIDTH-1:0];
            4'h7: next_rd_data = CONFIG_WORD[DATA_WIDTH-1:0];
            default:
            begin
                if (is_user)
                begin
                    next_rd_data = user_id[i_addr[1:0]];
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            for (int k = 0; k < 4; k++)
            begin
                user_id[k] <= '1;
            end
            o_rd_data <= '0;
        end
        else
        begin
            if (i_wr_en && is_user)
            begin
                user_id[i_addr[1:0]] <= i_wr_data; // R5
            end
            o_rd_data <= next_rd_data;
        end
    end
endmodule // nvmrap_config_space

/* rtl/nvmrap_defines.svh */
// Constants for the nonvolatile memory read access port
// Overview of operation
// R1: Indirect pointer reads fetch program flash contents
// R2: Indirect read stalls core exactly one cycle
// R3: Indirect read returns one byte to core
// R4: Indirect stores never write or erase memory
// R5: Register port reads all; writes limited regions
// R6: Write protect blocks every write and erase
// R7: Software picks region before read
// R8: Software loads address pair before read
// R9: Software starts read by setting strobe bit
// R10: Core stalled during read, resumes at once
// R11: Word appears in data pair next cycle
// R12: Data pair holds until read or write
// R13: Hardware clears read strobe on completion
`ifndef NVMRAP_DEFINES_SVH
`define NVMRAP_DEFINES_SVH
`define NVMRAP_OFS_CTRL 4'h0
`define NVMRAP_OFS_ADRL 4'h1
`define NVMRAP_OFS_ADRH 4'h2
`define NVMRAP_OFS_DATL 4'h3
`define NVMRAP_OFS_DATH 4'h4
`define NVMRAP_OFS_STAT 4'h5
`define NVMRAP_BIT_RD 0
`define NVMRAP_BIT_WR 1
`define NVMRAP_BIT_REGS 6
`define NVMRAP_BIT_WREN 2
`define NVMRAP_BIT_WRERR 3
`define NVMRAP_CTRL_RESET 8'h00
`define NVMRAP_ADR_RESET 8'h00
`define NVMRAP_DAT_RESET 8'h00
`define NVMRAP_READ_CYCLES 1
`define NVMRAP_FLASH_BASE 16'h8000
`endif

/* rtl/nvmrap_memory.sv */
// Small synchronous memory holding the nonvolatile array contents
`timescale 1ns/100ps
module nvmrap_memory
#(
    parameter int ADDR_WIDTH = 11,
    parameter int DATA_WIDTH = 14
)
(
    // Clock
    input wire logic i_clk_sys,
    // Read port
    input wire logic [ADDR_WIDTH-1:0] i_rd_addr,
    output logic [DATA_WIDTH-1:0] o_rd_data,
    // Write port
    input wire logic i_wr_en,
    input wire logic [ADDR_WIDTH-1:0] i_wr_addr,
    input wire logic [DATA_WIDTH-1:0] i_wr_data
);
    logic [DATA_WIDTH-1:0] cells [0:(1<<ADDR_WIDTH)-1];

    initial
    begin
        if (ADDR_WIDTH < 1 || ADDR_WIDTH > 16 || DATA_WIDTH < 8
            || DATA_WIDTH > 16)
        begin
            $error("nvmrap_memory: unsupported width");
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_wr_en)
        begin
            cells[i_wr_addr] <= i_wr_data;
        end
        o_rd_data <= cells[i_rd_addr];
    end
endmodule // nvmrap_memory

/* rtl/nvmrap_pkg.sv */
// Types for the nonvolatile memory read access port
package nvmrap_pkg;
    typedef enum logic [2:0] {
        NVMRAP_IDLE = 3'b001,
        NVMRAP_PTR_READ = 3'b010,
        NVMRAP_REG_READ = 3'b100
    } nvmrap_state_type;
    typedef enum logic [1:0] {
        NVMRAP_SPACE_FLASH = 2'b01,
        NVMRAP_SPACE_CONFIG = 2'b10
    } nvmrap_space_type;
endpackage

/* rtl/nvmrap_top.sv */
// Nonvolatile memory read access port: pointer path and register port
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "nvmrap_defines.svh"
module nvmrap_top
#(
    parameter int ADDR_WIDTH = 11,
    parameter int DATA_WIDTH = 14
)
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Register port from the core
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    // Indirect pointer path from the core
    input wire logic [15:0] i_indirect_address_pointer,
    input wire logic i_ptr_rd,
    input wire logic i_ptr_wr,
    input wire logic [7:0] i_ptr_wdata,
    output logic [7:0] o_indirect_data_port,
    output logic o_ptr_valid,
    // Core stall and device state
    output logic o_core_stall,
    input wire logic i_write_protect,
    // Program loading port (bench or programmer)
    input wire logic i_load_en,
    input wire logic [ADDR_WIDTH-1:0] i_load_addr,
    input wire logic [DATA_WIDTH-1:0] i_load_data
);
    import nvmrap_pkg::*;

    initial
    begin
        if (ADDR_WIDTH < 1 || ADDR_WIDTH > 15 || DATA_WIDTH < 8
            || DATA_WIDTH > 16)
        begin
            $error("nvmrap_top: unsupported width");
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers and state
    logic [7:0] adr_low;
    logic [7:0] adr_high;
    logic [7:0] dat_low;
    logic [7:0] dat_high;
    logic region_select_bit;
    logic rd_strobe;
    logic wr_enable;
    logic wr_error;
    logic ptr_high_byte;
    nvmrap_state_type state;
    nvmrap_state_type next_state;

    wire logic [DATA_WIDTH-1:0] flash_word;
    wire logic [DATA_WIDTH-1:0] cfg_word;
    wire logic cfg_writable;

    ////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = (a == o);
    endfunction

    wire logic wr_ctrl = i_reg_wr && hit(i_reg_addr, `NVMRAP_OFS_CTRL);
    wire logic wr_adrl = i_reg_wr && hit(i_reg_addr, `NVMRAP_OFS_ADRL);
    wire logic wr_adrh = i_reg_wr && hit(i_reg_addr, `NVMRAP_OFS_ADRH);
    wire logic wr_datl = i_reg_wr && hit(i_reg_addr, `NVMRAP_OFS_DATL);
    wire logic wr_dath = i_reg_wr && hit(i_reg_addr, `NVMRAP_OFS_DATH);
    wire logic [15:0] reg_address = {adr_high, adr_low};
    wire logic [15:0] dat_word = {dat_high, dat_low};
    wire logic [15:0] flash_base = `NVMRAP_FLASH_BASE;

    // Pointer addresses at or above the flash base reach the flash
    wire logic ptr_in_flash =
        (i_indirect_address_pointer >= flash_base); // R1
    wire logic start_ptr = (state == NVMRAP_IDLE) && i_ptr_rd
        && ptr_in_flash;
    wire logic set_rd = wr_ctrl && i_reg_wdata[`NVMRAP_BIT_RD]; // R9
    wire logic start_reg = (state == NVMRAP_IDLE) && set_rd
        && !start_ptr;

    // Flash read address: pointer path takes priority
    wire logic [ADDR_WIDTH-1:0] flash_addr = start_ptr
        ? i_indirect_address_pointer[ADDR_WIDTH:1] // R1
        : reg_address[ADDR_WIDTH-1:0];

    // Write attempts: pointer stores are dropped but still set the write error flag
    wire logic ptr_store_dropped = i_ptr_wr; // R4
    wire logic reg_data_write = wr_ctrl && i_reg_wdata[`NVMRAP_BIT_WR]
        && wr_enable;
    wire logic cfg_write = reg_data_write && region_select_bit
        && cfg_writable && !i_write_protect; // R5 R6
    wire logic blocked_write = reg_data_write
        && (i_write_protect || !region_select_bit); // R6

    ////////////////////////////////////////////////////////////////////
    // Storage
    nvmrap_memory #(
        .ADDR_WIDTH(ADDR_WIDTH),
        .DATA_WIDTH(DATA_WIDTH)
    ) u_flash (
        .i_clk_sys(i_clk_sys),
        .i_rd_addr(flash_addr),
        .o_rd_data(flash_word),
        .i_wr_en(i_load_en),
        .i_wr_addr(i_load_addr),
        .i_wr_data(i_load_data)
    );

    nvmrap_config_space #(
        .DATA_WIDTH(DATA_WIDTH)
    ) u_config (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_addr(reg_address[3:0]),
        .i_wr_en(cfg_write),
        .i_wr_data(dat_word[DATA_WIDTH-1:0]),
        .o_rd_data(cfg_word),
        .o_writable(cfg_writable)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequencer: every read lasts one cycle
    always_comb
    begin
        case (state)
            NVMRAP_IDLE:
            begin
                if (start_ptr)
                begin
                    next_state = NVMRAP_PTR_READ; // R2
                end
                else if (start_reg)
                begin
                    next_state = NVMRAP_REG_READ; // R10
                end
                else
                begin
                    next_state = NVMRAP_IDLE;
                end
            end
            default: next_state = NVMRAP_IDLE; // R2 R10
        endcase
    end

    // Core waits only while a read is in flight
    assign o_core_stall = (state != NVMRAP_IDLE); // R2 R10

    wire logic reg_done = (state == NVMRAP_REG_READ);
    wire logic [15:0] read_word = region_select_bit
        ? 16'(cfg_word) : 16'(flash_word);
    wire logic [7:0] ptr_byte = ptr_high_byte
        ? 8'(flash_word >> 8) : flash_word[7:0];

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            state <= NVMRAP_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            region_select_bit <= 1'b0;
            wr_enable <= 1'b0;
            rd_strobe <= 1'b0;
            wr_error <= 1'b0;
        end
        else
        begin
            if (wr_ctrl && state == NVMRAP_IDLE)
            begin
                region_select_bit <= i_reg_wdata[`NVMRAP_BIT_REGS]; // R7
                wr_enable <= i_reg_wdata[`NVMRAP_BIT_WREN];
            end
            if (reg_done)
            begin
                rd_strobe <= 1'b0; // R13
            end
            else if (start_reg)
            begin
                rd_strobe <= 1'b1;
            end
            // Set wins over a software clear in the same cycle
            if (blocked_write || ptr_store_dropped)
            begin
                wr_error <= 1'b1; // R4 R6
            end
            else if (wr_ctrl && !i_reg_wdata[`NVMRAP_BIT_WRERR])
            begin
                wr_error <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Address and data registers
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            adr_low <= `NVMRAP_ADR_RESET;
            adr_high <= `NVMRAP_ADR_RESET;
            dat_low <= `NVMRAP_DAT_RESET;
            dat_high <= `NVMRAP_DAT_RESET;
        end
        else
        begin
            // Address frozen while a read uses it
            if (wr_adrl && state == NVMRAP_IDLE)
            begin
                adr_low <= i_reg_wdata; // R8
            end
            if (wr_adrh && state == NVMRAP_IDLE)
            begin
                adr_high <= i_reg_wdata; // R8
            end
            if (reg_done)
            begin
                dat_low <= read_word[7:0]; // R11 R12
                dat_high <= read_word[15:8]; // R11 R12
            end
            else
            begin
                if (wr_datl)
                begin
                    dat_low <= i_reg_wdata; // R12
                end
                if (wr_dath)
                begin
                    dat_high <= i_reg_wdata; // R12
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pointer path data and register read-back
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            ptr_high_byte <= 1'b0;
            o_indirect_data_port <= 8'h00;
            o_ptr_valid <= 1'b0;
        end
        else
        begin
            if (start_ptr)
            begin
                ptr_high_byte <= i_indirect_address_pointer[0];
            end
            o_ptr_valid <= (state == NVMRAP_PTR_READ);
            if (state == NVMRAP_PTR_READ)
            begin
                o_indirect_data_port <= ptr_byte; // R3
            end
        end
    end

    wire logic [7:0] ctrl_view = {1'b0, region_select_bit, 2'h0,
        wr_error, wr_enable, 1'b0, rd_strobe};
    logic [7:0] next_rdata;

    always_comb
    begin
        case (i_reg_addr)
            `NVMRAP_OFS_CTRL: next_rdata = ctrl_view;
            `NVMRAP_OFS_ADRL: next_rdata = adr_low;
            `NVMRAP_OFS_ADRH: next_rdata = adr_high;
            `NVMRAP_OFS_DATL: next_rdata = dat_low;
            `NVMRAP_OFS_DATH: next_rdata = dat_high;
            `NVMRAP_OFS_STAT: next_rdata = {7'h00, o_core_stall};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_reg_rdata <= 8'h00;
        end
        else if (i_reg_rd)
        begin
            o_reg_rdata <= next_rdata;
        end
        else
        begin
            o_reg_rdata <= 8'h00;
        end
    end
endmodule // nvmrap_top

/* sim/nvmrap_checker.sv */
// Assertions for the read access port
`timescale 1ns/100ps
`include "nvmrap_defines.svh"
module nvmrap_checker
#(
    parameter int ADDR_WIDTH = 11,
    parameter int DATA_WIDTH = 14
)
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Register port
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    // Pointer path and stall
    input wire logic [15:0] i_indirect_address_pointer,
    input wire logic i_ptr_rd,
    input wire logic [7:0] o_indirect_data_port,
    input wire logic o_ptr_valid,
    input wire logic o_core_stall
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);
    wire logic ptr_hi = i_indirect_address_pointer >= `NVMRAP_FLASH_BASE;
    wire logic ptr_go = i_ptr_rd && ptr_hi && !o_core_stall;
    wire logic rd_go = i_reg_wr && i_reg_addr == `NVMRAP_OFS_CTRL
        && i_reg_wdata[`NVMRAP_BIT_RD] && !o_core_stall && !ptr_go;
    ////////////////////////////////////////////////////////////
    a_ptr_one_stall:
    assert property (ptr_go |=> o_core_stall ##1 !o_core_stall)
        else $error("pointer read stall not one cycle");
    a_ptr_answer:
    assert property (ptr_go |-> ##2 o_ptr_valid)
        else $error("pointer read gave no byte");
    a_valid_cause:
    assert property (o_ptr_valid |-> $past(ptr_go, 2))
        else $error("byte valid without pointer read");
    a_rd_stall:
    assert property (rd_go |=> o_core_stall ##1 !o_core_stall)
        else $error("register read stall wrong");
    a_low_ignored:
    assert property (i_ptr_rd && !ptr_hi && !o_core_stall && !i_reg_wr
        |=> !o_core_stall)
        else $error("pointer below flash started a read");
    a_rdata_quiet:
    assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_unmapped_zero:
    assert property (i_reg_rd && i_reg_addr > `NVMRAP_OFS_STAT
        |=> o_reg_rdata == 8'h00)
        else $error("unmapped index not zero");
    a_data_hold:
    assert property (!o_ptr_valid |-> $stable(o_indirect_data_port))
        else $error("pointer byte changed without read");
    c_ptr_read: cover property (ptr_go);
    c_reg_read: cover property (rd_go);
    c_dat_read: cover property (i_reg_rd && i_reg_addr == `NVMRAP_OFS_DATH);
endmodule // nvmrap_checker
bind nvmrap_top nvmrap_checker #(.ADDR_WIDTH(ADDR_WIDTH),
    .DATA_WIDTH(DATA_WIDTH)) i_chk (.i_clk_sys, .i_reset, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_indirect_address_pointer, .i_ptr_rd, .o_indirect_data_port,
    .o_ptr_valid, .o_core_stall);

/* sim/nvmrap_core_model.sv */
// Core side model issuing indirect pointer reads and stores
`timescale 1ns/100ps
module nvmrap_core_model
(
    // Clock
    input wire logic i_clk_sys,
    // Answers from the port
    input wire logic [7:0] i_data,
    input wire logic i_valid,
    input wire logic i_stall,
    // Requests to the port
    output logic [15:0] o_pointer,
    output logic o_rd,
    output logic o_wr,
    output logic [7:0] o_wdata
);
    initial
    begin
        o_pointer = 16'h0000;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////
    // Released lines show the inverse so stale values never match
    task automatic fetch(input logic [15:0] p, output logic [7:0] b,
        output int s);
        s = 0;
        @(posedge i_clk_sys);
        o_rd <= 1'b1;
        o_pointer <= p;
        @(posedge i_clk_sys);
        o_rd <= 1'b0;
        o_pointer <= ~p;
        repeat (6)
        begin
            #1;
            if (i_valid)
                break;
            s += int'(i_stall);
            @(posedge i_clk_sys);
        end
        b = i_data;
    endtask
    task automatic store(input logic [15:0] p, input logic [7:0] d);
        @(posedge i_clk_sys);
        o_wr <= 1'b1;
        o_pointer <= p;
        o_wdata <= d;
        @(posedge i_clk_sys);
        o_wr <= 1'b0;
        o_pointer <= ~p;
        o_wdata <= ~d;
    endtask
endmodule // nvmrap_core_model

/* sim/tb_top.sv */
// Self-checking bench for the read access port
`timescale 1ns/100ps
`include "nvmrap_defines.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic [3:0] i_reg_addr = 4'h0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [7:0] o_reg_rdata;
    logic [15:0] i_indirect_address_pointer;
    logic i_ptr_rd;
    logic i_ptr_wr;
    logic [7:0] i_ptr_wdata;
    logic [7:0] o_indirect_data_port;
    logic o_ptr_valid;
    logic o_core_stall;
    logic i_write_protect = 1'b0;
    logic i_load_en = 1'b0;
    logic [10:0] i_load_addr = 11'h000;
    logic [13:0] i_load_data = 14'h0000;
    int fail_count = 0;
    int checks_done = 0;
    logic [10:0] adrs [4] = '{11'h000, 11'h001, 11'h2aa, 11'h7ff};
    always #20 i_clk_sys = ~i_clk_sys;
    nvmrap_top #(.ADDR_WIDTH(11), .DATA_WIDTH(14)) i_dut (.i_clk_sys,
        .i_reset, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
        .o_reg_rdata, .i_indirect_address_pointer, .i_ptr_rd, .i_ptr_wr,
        .i_ptr_wdata, .o_indirect_data_port, .o_ptr_valid, .o_core_stall,
        .i_write_protect, .i_load_en, .i_load_addr, .i_load_data);
    nvmrap_core_model i_core (.i_clk_sys, .i_data(o_indirect_data_port),
        .i_valid(o_ptr_valid), .i_stall(o_core_stall),
        .o_pointer(i_indirect_address_pointer), .o_rd(i_ptr_rd),
        .o_wr(i_ptr_wr), .o_wdata(i_ptr_wdata));
    ////////////////////////////////////////////////////////////
    function automatic logic [15:0] wd(logic [10:0] a);
        return {2'b00, a[5:0], ~a[7:0]};
    endfunction
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        #1;
        d = o_reg_rdata;
    endtask
    task automatic do_read(input logic rs, input logic [10:0] a,
        output logic [15:0] w);
        reg_wr(`NVMRAP_OFS_CTRL, {1'b0, rs, 6'h00});
        reg_wr(`NVMRAP_OFS_ADRL, a[7:0]);
        reg_wr(`NVMRAP_OFS_ADRH, {5'h00, a[10:8]});
        reg_wr(`NVMRAP_OFS_CTRL, {1'b0, rs, 6'h01});
        #1;
        `CHK(o_core_stall, 1'b1)
        reg_rd(`NVMRAP_OFS_DATL, w[7:0]);
        `CHK(o_core_stall, 1'b0)
        reg_rd(`NVMRAP_OFS_DATH, w[15:8]);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reg_read();
        logic [15:0] w;
        logic [7:0] b;
        foreach (adrs[i])
        begin
            do_read(1'b0, adrs[i], w);
            `CHK(w, wd(adrs[i]))
            reg_rd(`NVMRAP_OFS_CTRL, b);
            `CHK(b[0], 1'b0)
        end
        reg_rd(4'h9, b);
        `CHK(b, 8'h00)
        reg_rd(`NVMRAP_OFS_STAT, b);
        `CHK(b, 8'h00)
        $display("register read test done");
    endtask
    task automatic t_ptr_read();
        logic [15:0] w;
        logic [7:0] b;
        int s;
        foreach (adrs[i])
            for (int k = 0; k < 2; k++)
            begin
                w = wd(adrs[i]);
                i_core.fetch({4'h8, adrs[i], k[0]}, b, s);
                `CHK(s, 1)
                `CHK(b, k ? w[15:8] : w[7:0])
            end
        i_core.fetch(16'h7ffe, b, s);
        `CHK(s, 0)
        `CHK(o_indirect_data_port, w[15:8])
        $display("pointer read test done");
    endtask
    task automatic t_hold();
        logic [15:0] w;
        logic [7:0] b;
        int s;
        do_read(1'b0, 11'h2aa, w);
        i_core.fetch(16'h8000, b, s);
        reg_rd(`NVMRAP_OFS_DATL, b);
        w = wd(11'h2aa);
        `CHK(b, w[7:0])
        reg_wr(`NVMRAP_OFS_DATL, 8'hc3);
        reg_rd(`NVMRAP_OFS_DATL, b);
        `CHK(b, 8'hc3)
        $display("hold test done");
    endtask
    task automatic t_store();
        logic [15:0] w;
        logic [7:0] b;
        i_core.store(16'h8000, 8'h00);
        reg_rd(`NVMRAP_OFS_CTRL, b);
        `CHK(b[`NVMRAP_BIT_WRERR], 1'b1)
        do_read(1'b0, 11'h000, w);
        `CHK(w, wd(11'h000))
        $display("store test done");
    endtask
    // First pass protected, second pass open
    task automatic t_user_id();
        logic [15:0] w;
        logic [15:0] v;
        logic [7:0] b;
        i_write_protect <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            reg_wr(`NVMRAP_OFS_DATL, 8'h11);
            reg_wr(`NVMRAP_OFS_DATH, 8'h05);
            reg_wr(`NVMRAP_OFS_ADRL, 8'h00);
            reg_wr(`NVMRAP_OFS_ADRH, 8'h00);
            // Write enable must stand before the write start
            reg_wr(`NVMRAP_OFS_CTRL, 8'h44);
            reg_wr(`NVMRAP_OFS_CTRL, 8'h46);
            reg_rd(`NVMRAP_OFS_CTRL, b);
            `CHK(b[`NVMRAP_BIT_WRERR], k == 0)
            repeat (3) @(posedge i_clk_sys);
            do_read(1'b1, 11'h000, w);
            `CHK(w, k ? 16'h0511 : 16'h3fff)
            i_write_protect <= 1'b0;
        end
        // Configuration word ignores a write start
        do_read(1'b1, 11'h007, w);
        reg_wr(`NVMRAP_OFS_DATL, 8'h00);
        reg_wr(`NVMRAP_OFS_DATH, 8'h00);
        reg_wr(`NVMRAP_OFS_CTRL, 8'h44);
        reg_wr(`NVMRAP_OFS_CTRL, 8'h46);
        do_read(1'b1, 11'h007, v);
        `CHK(v, w)
        $display("user id test done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        foreach (adrs[i])
        begin
            @(posedge i_clk_sys);
            i_load_en <= 1'b1;
            i_load_addr <= adrs[i];
            i_load_data <= wd(adrs[i]) & 16'h3fff;
        end
        @(posedge i_clk_sys);
        i_load_en <= 1'b0;
        t_reg_read();
        t_ptr_read();
        t_hold();
        t_store();
        t_user_id();
        conclude();
    end
    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge i_clk_sys);
        fail_count++;
        conclude();
    end
endmodule // tb_top
